/* hw/rpto_top.sv */
/*
  Root-port turn-off handshake: queues outbound packets, inserts the
  turn-off message in order, records the acknowledge and idles the link.
  Assumes the link layer gives one-cycle event pulses and valid/ready
  packet handshakes, all on CLK.
*/
`timescale 1ns/1ps
`default_nettype none
module rpto_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Firmware control and status
  input wire logic POWER_DOWN_REQUEST_BIT,
  input wire logic ACK_STATUS_CLR,
  output logic ACK_STATUS,
  output logic LINK_ELEC_IDLE,
  // Outbound packets from the core
  input wire logic OB_VALID,
  input wire rpto_pkg::rpto_pkt_t OB_PKT,
  output logic OB_READY,
  // Outbound packets to the link
  output logic TX_VALID,
  output rpto_pkg::rpto_pkt_t TX_PKT,
  input wire logic TX_READY,
  // Inbound events and packets from the link
  input wire rpto_pkg::rpto_rx_evt_t RX_EVT,
  input wire logic RX_VALID,
  input wire logic [rpto_pkg::RPTO_DW-1:0] RX_DATA,
  output logic RX_READY,
  // Inbound packets toward the core
  output logic IB_VALID,
  output logic [rpto_pkg::RPTO_DW-1:0] IB_DATA,
  input wire logic IB_READY
);
  import rpto_pkg::*;

  // Queue pointers and count
  logic [RPTO_AW-1:0] wr_ptr_ff;
  logic [RPTO_AW-1:0] rd_ptr_ff;
  logic [RPTO_AW:0] cnt_ff;
  // Handshake state and request edge
  rpto_state_t state_ff;
  logic req_d_ff;
  // Turn-off waiting for a queue slot
  logic pend_ff;
  // Read-out stage
  logic out_vld_ff;
  rpto_pkt_t mem_q;
  // Fresh memory word this cycle, else the held copy
  logic pop_d_ff;
  rpto_pkt_t hold_ff;
  // Queue push/pop controls
  logic push;
  logic pop;
  logic full;
  rpto_pkt_t push_pkt;
  logic req_rise;

  // Request edge; a falling edge sends nothing
  assign req_rise = POWER_DOWN_REQUEST_BIT & ~req_d_ff;
  assign full = (cnt_ff == (RPTO_AW+1)'(RPTO_DEPTH));
  // Turn-off goes in behind all earlier packets
  assign push = ~full & (pend_ff | (OB_VALID & ~LINK_ELEC_IDLE));
  assign OB_READY = ~full & ~pend_ff & ~LINK_ELEC_IDLE;
  // Payload of the queued entry
  always_comb begin
    push_pkt = OB_PKT;
    if (pend_ff) begin
      push_pkt.turn_off = 1'b1;
      push_pkt.data = '0;
    end else begin
      push_pkt.turn_off = 1'b0;
    end
  end
  // Pop when stage empty or its packet leaves
  assign pop = (cnt_ff != '0) & (~out_vld_ff | (TX_VALID & TX_READY));

  // Packet memory
  rpto_mem u_mem (
    .CLK(CLK),
    .wr_en(push),
    .wr_addr(wr_ptr_ff),
    .wr_data(push_pkt),
    .rd_addr(rd_ptr_ff),
    .rd_data(mem_q)
  );

  // Request edge register
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      req_d_ff <= RPTO_REQ_RST;
    end else begin
      req_d_ff <= POWER_DOWN_REQUEST_BIT;
    end
  end

  // Pending turn-off message
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pend_ff <= 1'b0;
    end else if (req_rise && state_ff == RPTO_ST_RUN) begin
      pend_ff <= 1'b1;
    end else if (push) begin
      pend_ff <= 1'b0;
    end
  end

  // Queue pointers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (RPTO_AW+1)'(push) - (RPTO_AW+1)'(pop);
    end
  end

  // Output stage valid
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      out_vld_ff <= 1'b0;
    end else if (pop) begin
      out_vld_ff <= 1'b1;
    end else if (TX_READY) begin
      out_vld_ff <= 1'b0;
    end
  end
  assign TX_VALID = out_vld_ff;

  // Pop marker; the memory re-reads the next slot after a pop
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pop_d_ff <= 1'b0;
    end else begin
      pop_d_ff <= pop;
    end
  end

  // Hold the word on offer so a stalled packet never changes
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      hold_ff <= '0;
    end else begin
      hold_ff <= TX_PKT;
    end
  end
  assign TX_PKT = pop_d_ff ? mem_q : hold_ff;

  // Handshake state
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_ff <= RPTO_ST_RUN;
    end else begin
      case (state_ff)
        RPTO_ST_RUN: begin
          if (req_rise) begin
            state_ff <= RPTO_ST_SENT;
          end
        end
        RPTO_ST_SENT: begin
          // Enter-L23 moves link to idle
          if (RX_EVT.enter_l23) begin
            state_ff <= RPTO_ST_IDLE;
          end
        end
        RPTO_ST_IDLE: begin
          // Firmware clearing request rearms
          if (!POWER_DOWN_REQUEST_BIT) begin
            state_ff <= RPTO_ST_RUN;
          end
        end
        default: begin
          state_ff <= RPTO_ST_RUN;
        end
      endcase
    end
  end
  assign LINK_ELEC_IDLE = (state_ff == RPTO_ST_IDLE);

  // Sticky acknowledged status; set wins over clear
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ACK_STATUS <= RPTO_ACK_RST;
    end else if (RX_EVT.to_ack && state_ff != RPTO_ST_RUN) begin
      ACK_STATUS <= 1'b1;
    end else if (ACK_STATUS_CLR) begin
      ACK_STATUS <= 1'b0;
    end
  end

  // Inbound path passes through unchanged
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      IB_VALID <= 1'b0;
      IB_DATA <= '0;
    end else if (RX_READY) begin
      IB_VALID <= RX_VALID;
      IB_DATA <= RX_DATA;
    end
  end
  assign RX_READY = ~IB_VALID | IB_READY;
endmodule : rpto_top
`default_nettype wire

/* hw/rpto_pkg.sv */
/*
  Package for the root-port power-off handshake block: carrier structs,
  states and reset values.
  Assumes a single core clock and a synchronous active-low reset.
*/
package rpto_pkg;
  // Packet payload width
  localparam int RPTO_DW = 32;
  // Outbound queue depth and pointer width
  localparam int RPTO_DEPTH = 16;
  localparam int RPTO_AW = 4;
  // Reset values of control state
  localparam logic RPTO_REQ_RST = 1'b0;
  localparam logic RPTO_ACK_RST = 1'b0;
  localparam logic RPTO_IDLE_RST = 1'b0;

  // Outbound packet: turn-off marker plus data
  typedef struct packed {
    logic turn_off;
    logic [RPTO_DW-1:0] data;
  } rpto_pkt_t;

  // Inbound link events reported by the link layer
  typedef struct packed {
    logic to_ack;
    logic enter_l23;
  } rpto_rx_evt_t;

  // Handshake progress
  typedef enum logic [1:0] {
    RPTO_ST_RUN,
    RPTO_ST_SENT,
    RPTO_ST_IDLE
  } rpto_state_t;
endpackage : rpto_pkg

/* hw/rpto_mem.sv */
/*
  Small register-file memory holding outbound packets in order.
  Assumes the writer never writes and reads the same slot in one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module rpto_mem (
  // Clock
  input wire logic CLK,
  // Write side
  input wire logic wr_en,
  input wire logic [rpto_pkg::RPTO_AW-1:0] wr_addr,
  input wire rpto_pkg::rpto_pkt_t wr_data,
  // Read side, registered data
  input wire logic [rpto_pkg::RPTO_AW-1:0] rd_addr,
  output rpto_pkg::rpto_pkt_t rd_data
);
  import rpto_pkg::*;
  // Storage array
  rpto_pkt_t mem_ff [RPTO_DEPTH];

  // Write port
  always_ff @(posedge CLK) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  // Registered read
  always_ff @(posedge CLK) begin
    rd_data <= mem_ff[rd_addr];
  end
endmodule : rpto_mem
`default_nettype wire

/* tb/rpto_sva.sv */
/* Port checker for rpto_top.
   Assumes the bind below and one clock. */
`timescale 1ns/1ps
`default_nettype none
module rpto_sva (
  // Watched ports
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic POWER_DOWN_REQUEST_BIT,
  input wire logic ACK_STATUS_CLR,
  input wire logic ACK_STATUS,
  input wire logic LINK_ELEC_IDLE,
  input wire logic TX_VALID,
  input wire rpto_pkg::rpto_pkt_t TX_PKT,
  input wire logic TX_READY,
  input wire rpto_pkg::rpto_rx_evt_t RX_EVT
);
  import rpto_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Turn-off leaving on the link
  sequence s_off_out;
    TX_VALID && TX_READY && TX_PKT.turn_off;
  endsequence
  a_req_sends_off: assert property (
    $rose(POWER_DOWN_REQUEST_BIT) && !LINK_ELEC_IDLE |-> ##[1:60] s_off_out)
    else $error("turn-off not sent");
  a_off_once: assert property (
    $fell(POWER_DOWN_REQUEST_BIT) |-> !(TX_VALID && TX_PKT.turn_off) [*8])
    else $error("turn-off after clear");
  a_ack_sets: assert property (RX_EVT.to_ack |=> ACK_STATUS)
    else $error("status not set");
  a_ack_sticky: assert property (
    ACK_STATUS && !ACK_STATUS_CLR |=> ACK_STATUS)
    else $error("status lost");
  a_l23_idles: assert property (
    RX_EVT.enter_l23 && POWER_DOWN_REQUEST_BIT |=> LINK_ELEC_IDLE)
    else $error("link not idle");
  a_idle_holds: assert property (
    LINK_ELEC_IDLE && POWER_DOWN_REQUEST_BIT |=> LINK_ELEC_IDLE)
    else $error("idle dropped");
  a_tx_stands: assert property (
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_PKT))
    else $error("packet changed");
endmodule : rpto_sva
bind rpto_top rpto_sva rpto_sva_i (.CLK, .RST_N, .POWER_DOWN_REQUEST_BIT,
  .ACK_STATUS_CLR, .ACK_STATUS, .LINK_ELEC_IDLE, .TX_VALID, .TX_PKT, .TX_READY,
  .RX_EVT);
`default_nettype wire

/* tb/rpto_dn_model.sv */
/* Downstream device model: drains the link, answers turn-off.
   Assumes rpto_top on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module rpto_dn_model (
  // Clock, reset, stall
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic STALL,
  // Link side
  input wire logic TX_VALID,
  input wire rpto_pkg::rpto_pkt_t TX_PKT,
  input wire logic LINK_ELEC_IDLE,
  output logic TX_READY,
  output rpto_pkg::rpto_rx_evt_t RX_EVT
);
  import rpto_pkg::*;
  logic [3:0] wait_ff; // Drain time before acknowledging
  logic got_ff; // Turn-off seen
  logic l23_ff; // Enter-L23 repeating
  assign TX_READY = !STALL;
  // Reply sequence
  always_ff @(posedge CLK) begin
    RX_EVT <= '0;
    if (!RST_N) begin
      got_ff <= 1'b0;
      l23_ff <= 1'b0;
    end else if (TX_VALID && TX_READY && TX_PKT.turn_off) begin
      got_ff <= 1'b1;
      // Drain time also covers acks of subordinate ports
      wait_ff <= 4'h6;
    end else if (got_ff && wait_ff != 4'h0) begin
      wait_ff <= wait_ff - 4'h1;
    end else if (got_ff) begin
      RX_EVT.to_ack <= 1'b1;
      got_ff <= 1'b0;
      l23_ff <= 1'b1;
    end else if (l23_ff && !LINK_ELEC_IDLE) begin
      RX_EVT.enter_l23 <= !RX_EVT.enter_l23;
    end else begin
      l23_ff <= 1'b0;
    end
  end
endmodule : rpto_dn_model
`default_nettype wire

/* tb/rpto_top_tb.sv */
/* Bench for rpto_top with downstream model.
   Assumes a 25 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module rpto_top_tb;
  import rpto_pkg::*;
  logic clk = 0, rst_n = 0, req = 0, clr = 0, obv = 0, rxv = 0, stall = 0;
  logic ack, idle, obr, txv, txr, rxr, ibv;
  logic [31:0] rxd = '0, ibd;
  rpto_pkt_t obp = '0, txp;
  rpto_rx_evt_t evt;
  rpto_pkt_t txq[$]; // Packets seen on the link
  int err_total = 0, compares = 0, cyc = 0;
  always #20 clk = ~clk;
  rpto_top rpto_top_i (.CLK(clk), .RST_N(rst_n), .POWER_DOWN_REQUEST_BIT(req),
    .ACK_STATUS_CLR(clr), .ACK_STATUS(ack), .LINK_ELEC_IDLE(idle), .OB_VALID(obv),
    .OB_PKT(obp), .OB_READY(obr), .TX_VALID(txv), .TX_PKT(txp), .TX_READY(txr),
    .RX_EVT(evt), .RX_VALID(rxv), .RX_DATA(rxd), .RX_READY(rxr), .IB_VALID(ibv),
    .IB_DATA(ibd), .IB_READY(1'b1));
  rpto_dn_model rpto_dn_model_i (.CLK(clk), .RST_N(rst_n), .STALL(stall),
    .TX_VALID(txv), .TX_PKT(txp), .LINK_ELEC_IDLE(idle), .TX_READY(txr), .RX_EVT(evt));
  always @(posedge clk) if (rst_n && txv && txr) txq.push_back(txp);
  always @(posedge clk) if (++cyc == 3000) begin
    err_total++;
    summarize();
  end
  task automatic tick(); @(posedge clk); #1; endtask : tick
  task automatic chk(input logic c, input string m);
    compares++;
    if (c !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic summarize();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic send(input logic [31:0] d);
    obv = 1;
    obp = '{1'b0, d};
    while (obr !== 1'b1) tick();
    tick();
  endtask : send
  // Queued traffic, turn-off, inbound, sticky status
  task automatic sc_order();
    stall = 1;
    send(32'hA1);
    send(32'hB2);
    send(32'hC3);
    obv = 0;
    req = 1;
    repeat (4) tick();
    stall = 0;
    repeat (40) if (txq.size() < 4) tick();
    rxv = 1;
    rxd = 32'h5A;
    while (rxr !== 1'b1) tick();
    tick();
    rxv = 0;
    while (ibv !== 1'b1) tick();
    chk(ibd === 32'h5A, "inbound lost");
    chk(txq[0].data === 32'hA1 && txq[2].data === 32'hC3, "order");
    chk(txq[3].turn_off === 1'b1 && txq[2].turn_off === 1'b0, "turn-off");
    repeat (60) if (idle !== 1'b1) tick();
    chk(ack === 1'b1 && idle === 1'b1, "no ack or idle");
    chk(obr === 1'b0, "accept while idle");
    req = 0;
    repeat (8) tick();
    chk(txq.size() == 4 && ack === 1'b1 && idle === 1'b0, "clear");
    clr = 1;
    tick();
    clr = 0;
    tick();
    chk(ack === 1'b0, "status stuck");
  endtask : sc_order
  // Second handshake after return to run
  task automatic sc_repeat();
    req = 1;
    repeat (80) if (idle !== 1'b1) tick();
    chk(txq.size() == 5 && txq[4].turn_off === 1'b1 && ack === 1'b1, "round two");
    req = 0;
    tick();
  endtask : sc_repeat
  initial begin
    repeat (8) tick();
    rst_n = 1;
    sc_order();
    sc_repeat();
    summarize();
  end
endmodule : rpto_top_tb
`default_nettype wire
